// ---- mfab_defines.svh ----
/*
  attribute identifiers, field positions and reset values of the functional attribute bank.
  assumes inclusion by bare name; definitions only.
*/
`ifndef MFAB_DEFINES_SVH
`define MFAB_DEFINES_SVH

`define MFAB_ID_LOCAL_NODE_ID 16'h0020
`define MFAB_ID_LOCAL_SWITCH_ID 16'h0021
`define MFAB_ID_UPSTREAM_SWITCH_ID 16'h0022
`define MFAB_ID_SUBNETWORK_ADDRESS 16'h0023
`define MFAB_ID_NODE_FUNCTIONAL_STATE 16'h0024
`define MFAB_ID_CONTENTION_PERIOD_LENGTH 16'h0025
`define MFAB_ID_HIERARCHY_LEVEL 16'h0026
`define MFAB_ID_BEACON_SLOT_COUNT 16'h0027
`define MFAB_ID_BEACON_RECEIVE_SLOT 16'h0028
`define MFAB_ID_BEACON_TRANSMIT_SLOT 16'h0029
`define MFAB_ID_BEACON_RECEIVE_INTERVAL 16'h002A
`define MFAB_ID_BEACON_TRANSMIT_INTERVAL 16'h002B
`define MFAB_ID_CAPABILITY_BITMAP 16'h002C

`define MFAB_STATE_DISCONNECTED 2'h0
`define MFAB_STATE_TERMINAL 2'h1
`define MFAB_STATE_SWITCH 2'h2
`define MFAB_STATE_BASE 2'h3

`define MFAB_NODE_ID_MAX 16'h3FFF
`define MFAB_LEVEL_MASK 8'h3F
`define MFAB_SLOT_MASK 8'h07
`define MFAB_INTERVAL_MASK 8'h1F
`define MFAB_CAP_VALID_MASK 16'h0F7F

`define MFAB_CAP_SWITCH_BIT 0
`define MFAB_CAP_AGGREGATION_BIT 1
`define MFAB_CAP_CONTENTION_FREE_BIT 2
`define MFAB_CAP_DIRECT_CONN_BIT 3
`define MFAB_CAP_MULTICAST_BIT 4
`define MFAB_CAP_ROBUSTNESS_BIT 5
`define MFAB_CAP_REPEAT_REQ_BIT 6
`define MFAB_CAP_DIRECT_SW_BIT 8
`define MFAB_CAP_MULTICAST_SW_BIT 9
`define MFAB_CAP_ROBUSTNESS_SW_BIT 10
`define MFAB_CAP_REPEAT_BUF_SW_BIT 11

`define MFAB_RESET_VALUE_48 48'h000000000000
`define MFAB_RESET_VALUE_16 16'h0000
`define MFAB_RESET_VALUE_8 8'h00

`endif

// ---- mfab_pkg.sv ----
/*
  types of the functional attribute bank.
  assumes nothing of its surroundings.
*/
`default_nettype none
package mfab_pkg;
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] attr_id;
  } mfab_request_type;

  typedef struct packed {
    logic valid;
    logic hit;
    logic [47:0] data;
  } mfab_answer_type;

  typedef struct packed {
    logic [15:0] local_node_id;
    logic [7:0] local_switch_id;
    logic [7:0] upstream_switch_id;
    logic [47:0] subnetwork_address;
    logic [1:0] node_functional_state;
    logic [15:0] contention_period_length;
    logic [7:0] hierarchy_level;
    logic [7:0] beacon_slot_count;
    logic [7:0] beacon_receive_slot;
    logic [7:0] beacon_transmit_slot;
    logic [7:0] beacon_receive_interval;
    logic [7:0] beacon_transmit_interval;
    logic [15:0] capability_bitmap;
  } mfab_attr_type;
endpackage
`default_nettype wire

// ---- mfab_bank.sv ----
/*
  read-only functional attribute bank of a power line mac node.
  assumes the mac logic presents attribute values with a one-cycle load strobe
  and the management side issues single-cycle get or set requests.
*/
// Notes on behaviour
// R1: attributes readable only; set requests change nothing
// R2: requester supplies identifier with every read
// R3: 16-bit node id, 0..16383, at 0x20
// R4: 8-bit switch id, unused in terminal
// R5: upstream switch id, unused in base
// R6: 48-bit subnetwork address at 0x23
// R7: state code 0 disc,1 term,2 sw,3 base
// R8: 16-bit contention length in symbols
// R9: hierarchy level 0..63 at 0x26
// R10: beacon slot count 0..7 at 0x27
// R11: receive beacon slot, unused in base
// R12: transmit beacon slot, unused in terminal
// R13: receive interval 0..31, unused in base
// R14: transmit interval 0..31, unused in terminal
// R15: 16-bit capability bitmap, bit 0 rightmost
// R16: capability bits 0..6 node features
// R17: bits 8..11 switching; 7,12..15 reserved
// R18: reserved and unmaintained values read zero
`timescale 1ns/1ps
`default_nettype none
`include "mfab_defines.svh"

module mfab_bank (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_attr_load,
  input wire mfab_pkg::mfab_attr_type i_attr,
  input wire mfab_pkg::mfab_request_type i_req,
  output var mfab_pkg::mfab_answer_type o_ans
);

  typedef enum logic [1:0] {
    MFAB_IDLE = 2'b01,
    MFAB_ANSWER = 2'b10
  } mfab_phase_type;

  mfab_pkg::mfab_attr_type store;
  mfab_phase_type phase;
  mfab_phase_type next_phase;
  mfab_pkg::mfab_answer_type next_ans;

  function automatic logic [7:0] mfab_clip8(input logic [7:0] value, input logic [7:0] mask);
    mfab_clip8 = value & mask;
  endfunction

  function automatic logic mfab_is_role(input logic [1:0] state, input logic [1:0] role);
    mfab_is_role = (state == role);
  endfunction

  // capture from the mac side only; no path from requests reaches the store [R1]
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      store <= '0;
    end else if (i_attr_load) begin
      store.local_node_id <= (i_attr.local_node_id > `MFAB_NODE_ID_MAX) ?
        `MFAB_NODE_ID_MAX : i_attr.local_node_id; // [R3]
      store.local_switch_id <= i_attr.local_switch_id; // [R4]
      store.upstream_switch_id <= i_attr.upstream_switch_id; // [R5]
      store.subnetwork_address <= i_attr.subnetwork_address; // [R6]
      store.node_functional_state <= i_attr.node_functional_state; // [R7]
      store.contention_period_length <= i_attr.contention_period_length; // [R8]
      store.hierarchy_level <= mfab_clip8(i_attr.hierarchy_level, `MFAB_LEVEL_MASK); // [R9]
      store.beacon_slot_count <= mfab_clip8(i_attr.beacon_slot_count, `MFAB_SLOT_MASK); // [R10]
      store.beacon_receive_slot <= mfab_clip8(i_attr.beacon_receive_slot,
        `MFAB_SLOT_MASK); // [R11]
      store.beacon_transmit_slot <= mfab_clip8(i_attr.beacon_transmit_slot,
        `MFAB_SLOT_MASK); // [R12]
      store.beacon_receive_interval <= mfab_clip8(i_attr.beacon_receive_interval,
        `MFAB_INTERVAL_MASK); // [R13]
      store.beacon_transmit_interval <= mfab_clip8(i_attr.beacon_transmit_interval,
        `MFAB_INTERVAL_MASK); // [R14]
      // reserved bits cleared on entry so readback never leaks them [R17]
      store.capability_bitmap <= i_attr.capability_bitmap & `MFAB_CAP_VALID_MASK; // [R15]
    end
  end

  always_comb begin
    next_phase = i_req.valid ? MFAB_ANSWER : MFAB_IDLE;
  end

  // one fixed cycle of latency; each request answered the cycle after [R2]
  always_comb begin
    logic terminal;
    logic base;
    terminal = mfab_is_role(store.node_functional_state, `MFAB_STATE_TERMINAL);
    base = mfab_is_role(store.node_functional_state, `MFAB_STATE_BASE);
    next_ans = '0;
    next_ans.valid = i_req.valid;
    next_ans.hit = i_req.valid;
    unique case (i_req.attr_id)
      `MFAB_ID_LOCAL_NODE_ID: next_ans.data = {32'h0, store.local_node_id}; // [R3]
      `MFAB_ID_LOCAL_SWITCH_ID: next_ans.data = terminal ? 48'h0 :
        {40'h0, store.local_switch_id}; // [R4] [R18]
      `MFAB_ID_UPSTREAM_SWITCH_ID: next_ans.data = base ? 48'h0 :
        {40'h0, store.upstream_switch_id}; // [R5] [R18]
      `MFAB_ID_SUBNETWORK_ADDRESS: next_ans.data = store.subnetwork_address; // [R6]
      `MFAB_ID_NODE_FUNCTIONAL_STATE: next_ans.data = {46'h0,
        store.node_functional_state}; // [R7]
      `MFAB_ID_CONTENTION_PERIOD_LENGTH: next_ans.data = {32'h0,
        store.contention_period_length}; // [R8]
      `MFAB_ID_HIERARCHY_LEVEL: next_ans.data = {40'h0, store.hierarchy_level}; // [R9]
      `MFAB_ID_BEACON_SLOT_COUNT: next_ans.data = {40'h0, store.beacon_slot_count}; // [R10]
      `MFAB_ID_BEACON_RECEIVE_SLOT: next_ans.data = base ? 48'h0 :
        {40'h0, store.beacon_receive_slot}; // [R11] [R18]
      `MFAB_ID_BEACON_TRANSMIT_SLOT: next_ans.data = terminal ? 48'h0 :
        {40'h0, store.beacon_transmit_slot}; // [R12] [R18]
      `MFAB_ID_BEACON_RECEIVE_INTERVAL: next_ans.data = base ? 48'h0 :
        {40'h0, store.beacon_receive_interval}; // [R13] [R18]
      `MFAB_ID_BEACON_TRANSMIT_INTERVAL: next_ans.data = terminal ? 48'h0 :
        {40'h0, store.beacon_transmit_interval}; // [R14] [R18]
      `MFAB_ID_CAPABILITY_BITMAP: next_ans.data = {32'h0,
        store.capability_bitmap & `MFAB_CAP_VALID_MASK}; // [R15] [R16] [R17]
      default: next_ans.hit = 1'b0;
    endcase
    // set requests refused; idle cycles answer all zero [R1]
    if (i_req.write || !i_req.valid) begin
      next_ans.hit = 1'b0;
      next_ans.data = 48'h0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      phase <= MFAB_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_ans <= '0;
    end else begin
      o_ans <= next_ans; // [R2]
    end
  end

  property p_answer_follows;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_req.valid |=> o_ans.valid;
  endproperty
  a_answer_follows: assert property (p_answer_follows) // [R2]
    else $error("no answer after request");

  property p_set_refused;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_req.valid && i_req.write) |=> (!o_ans.hit && o_ans.data == 48'h0);
  endproperty
  a_set_refused: assert property (p_set_refused) else $error("set request not refused"); // [R1]

  property p_set_keeps_store;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_req.valid && i_req.write && !i_attr_load) |=> $stable(store);
  endproperty
  a_set_keeps_store: assert property (p_set_keeps_store) else $error("set changed value"); // [R1]

  property p_node_id_range;
    @(posedge i_ref_clk) disable iff (i_rst)
      store.local_node_id <= `MFAB_NODE_ID_MAX;
  endproperty
  a_node_id_range: assert property (p_node_id_range) else $error("node id out of range"); // [R3]

  property p_switch_id_terminal;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_req.valid && !i_req.write && i_req.attr_id == `MFAB_ID_LOCAL_SWITCH_ID &&
       store.node_functional_state == `MFAB_STATE_TERMINAL) |=> o_ans.data == 48'h0;
  endproperty
  a_switch_id_terminal: assert property (p_switch_id_terminal) // [R4]
    else $error("switch id leak");

  property p_upstream_base;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_req.valid && !i_req.write && i_req.attr_id == `MFAB_ID_UPSTREAM_SWITCH_ID &&
       store.node_functional_state == `MFAB_STATE_BASE) |=> o_ans.data == 48'h0;
  endproperty
  a_upstream_base: assert property (p_upstream_base) else $error("upstream id leak"); // [R5]

  property p_address_read;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_req.valid && !i_req.write && i_req.attr_id == `MFAB_ID_SUBNETWORK_ADDRESS &&
       !i_attr_load) |=> o_ans.data == store.subnetwork_address;
  endproperty
  a_address_read: assert property (p_address_read) else $error("address mismatch"); // [R6]

  property p_level_range;
    @(posedge i_ref_clk) disable iff (i_rst)
      store.hierarchy_level[7:6] == 2'h0 && store.beacon_slot_count[7:3] == 5'h0;
  endproperty
  a_level_range: assert property (p_level_range) // [R9]
    else $error("level or count out of range");

  property p_cap_reserved;
    @(posedge i_ref_clk) disable iff (i_rst)
      o_ans.data[7] == 1'b0 || !$past(i_req.attr_id == `MFAB_ID_CAPABILITY_BITMAP);
  endproperty
  a_cap_reserved: assert property (p_cap_reserved) else $error("reserved bit set"); // [R17]

  property p_unmapped_miss;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_req.valid && (i_req.attr_id < `MFAB_ID_LOCAL_NODE_ID ||
       i_req.attr_id > `MFAB_ID_CAPABILITY_BITMAP)) |=> !o_ans.hit;
  endproperty
  a_unmapped_miss: assert property (p_unmapped_miss) else $error("unmapped id hit"); // [R2]

  property p_phase_tracks;
    @(posedge i_ref_clk) disable iff (i_rst)
      (phase == MFAB_ANSWER) == o_ans.valid;
  endproperty
  a_phase_tracks: assert property (p_phase_tracks) else $error("phase mismatch"); // [R2]

  property p_idle_quiet;
    @(posedge i_ref_clk) disable iff (i_rst)
      !i_req.valid |=> (o_ans == '0);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("answer without request"); // [R2]

  property p_node_id_read;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_req.valid && !i_req.write && i_req.attr_id == `MFAB_ID_LOCAL_NODE_ID) |=>
      (o_ans.hit && o_ans.data == {32'h0, $past(store.local_node_id)});
  endproperty
  a_node_id_read: assert property (p_node_id_read) else $error("node id read wrong"); // [R3]

  property p_switch_id_read;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_req.valid && !i_req.write && i_req.attr_id == `MFAB_ID_LOCAL_SWITCH_ID &&
       store.node_functional_state != `MFAB_STATE_TERMINAL) |=>
      (o_ans.hit && o_ans.data == {40'h0, $past(store.local_switch_id)});
  endproperty
  a_switch_id_read: assert property (p_switch_id_read) else $error("switch id wrong"); // [R4]

  property p_upstream_read;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_req.valid && !i_req.write && i_req.attr_id == `MFAB_ID_UPSTREAM_SWITCH_ID &&
       store.node_functional_state != `MFAB_STATE_BASE) |=>
      (o_ans.hit && o_ans.data == {40'h0, $past(store.upstream_switch_id)});
  endproperty
  a_upstream_read: assert property (p_upstream_read) else $error("upstream id wrong"); // [R5]

  property p_base_address;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_req.valid && !i_req.write && i_req.attr_id == `MFAB_ID_SUBNETWORK_ADDRESS &&
       store.node_functional_state == `MFAB_STATE_BASE) |=>
      (o_ans.hit && o_ans.data == $past(store.subnetwork_address));
  endproperty
  a_base_address: assert property (p_base_address) else $error("base address wrong"); // [R6]

  property p_state_read;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_req.valid && !i_req.write && i_req.attr_id == `MFAB_ID_NODE_FUNCTIONAL_STATE) |=>
      (o_ans.hit && o_ans.data == {46'h0, $past(store.node_functional_state)});
  endproperty
  a_state_read: assert property (p_state_read) else $error("state read wrong"); // [R7]

  property p_contention_read;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_req.valid && !i_req.write && i_req.attr_id == `MFAB_ID_CONTENTION_PERIOD_LENGTH) |=>
      (o_ans.hit && o_ans.data == {32'h0, $past(store.contention_period_length)});
  endproperty
  a_contention_read: assert property (p_contention_read) else $error("length wrong"); // [R8]

  property p_level_read;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_req.valid && !i_req.write && i_req.attr_id == `MFAB_ID_HIERARCHY_LEVEL) |=>
      (o_ans.hit && o_ans.data[47:6] == 42'h0);
  endproperty
  a_level_read: assert property (p_level_read) else $error("level read out of range"); // [R9]

  property p_slot_count_read;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_req.valid && !i_req.write && i_req.attr_id == `MFAB_ID_BEACON_SLOT_COUNT) |=>
      (o_ans.hit && o_ans.data[47:3] == 45'h0);
  endproperty
  a_slot_count_read: assert property (p_slot_count_read) else $error("slot count wide"); // [R10]

  property p_rx_slot_base;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_req.valid && !i_req.write && i_req.attr_id == `MFAB_ID_BEACON_RECEIVE_SLOT &&
       store.node_functional_state == `MFAB_STATE_BASE) |=> o_ans.data == 48'h0;
  endproperty
  a_rx_slot_base: assert property (p_rx_slot_base) else $error("rx slot leak"); // [R11]

  property p_tx_slot_terminal;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_req.valid && !i_req.write && i_req.attr_id == `MFAB_ID_BEACON_TRANSMIT_SLOT &&
       store.node_functional_state == `MFAB_STATE_TERMINAL) |=> o_ans.data == 48'h0;
  endproperty
  a_tx_slot_terminal: assert property (p_tx_slot_terminal) else $error("tx slot leak"); // [R12]

  property p_rx_interval_base;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_req.valid && !i_req.write && i_req.attr_id == `MFAB_ID_BEACON_RECEIVE_INTERVAL &&
       store.node_functional_state == `MFAB_STATE_BASE) |=> o_ans.data == 48'h0;
  endproperty
  a_rx_interval_base: assert property (p_rx_interval_base) else $error("interval leak"); // [R13]

  property p_tx_interval_terminal;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_req.valid && !i_req.write && i_req.attr_id == `MFAB_ID_BEACON_TRANSMIT_INTERVAL &&
       store.node_functional_state == `MFAB_STATE_TERMINAL) |=> o_ans.data == 48'h0;
  endproperty
  a_tx_interval_terminal: assert property (p_tx_interval_terminal) // [R14]
    else $error("tx interval leak");

  property p_interval_range;
    @(posedge i_ref_clk) disable iff (i_rst)
      store.beacon_receive_interval[7:5] == 3'h0 && store.beacon_transmit_interval[7:5] == 3'h0;
  endproperty
  a_interval_range: assert property (p_interval_range) // [R13] [R14]
    else $error("interval out of range");

  property p_cap_read;
    @(posedge i_ref_clk) disable iff (i_rst)
      (i_req.valid && !i_req.write && i_req.attr_id == `MFAB_ID_CAPABILITY_BITMAP) |=>
      (o_ans.hit && o_ans.data[47:16] == 32'h0 &&
       o_ans.data[6:0] == $past(store.capability_bitmap[6:0]));
  endproperty
  a_cap_read: assert property (p_cap_read) else $error("capability read wrong"); // [R15] [R16]

  property p_cap_reserved_store;
    @(posedge i_ref_clk) disable iff (i_rst)
      store.capability_bitmap[15:12] == 4'h0 && store.capability_bitmap[7] == 1'b0;
  endproperty
  a_cap_reserved_store: assert property (p_cap_reserved_store) // [R17]
    else $error("reserved bit kept");

  property p_cap_switching;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_attr_load |=> store.capability_bitmap[11:8] == $past(i_attr.capability_bitmap[11:8]);
  endproperty
  a_cap_switching: assert property (p_cap_switching) // [R17]
    else $error("switching bits lost");

  property p_load_state;
    @(posedge i_ref_clk) disable iff (i_rst)
      i_attr_load |=> store.node_functional_state == $past(i_attr.node_functional_state);
  endproperty
  a_load_state: assert property (p_load_state) else $error("state not captured"); // [R7]

  c_get_hit: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    i_req.valid && !i_req.write ##1 o_ans.hit);
  c_set_refused: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    i_req.valid && i_req.write);
  c_base_read: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    i_req.valid && store.node_functional_state == `MFAB_STATE_BASE);
  c_back_to_back: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    i_req.valid [*2]);
  c_cap_read: cover property (@(posedge i_ref_clk) disable iff (i_rst)
    i_req.valid && i_req.attr_id == `MFAB_ID_CAPABILITY_BITMAP);

endmodule
`default_nettype wire

// ---- mfab_mgmt_model.sv ----
/*
  management entity model: issues get and set requests to the bank.
  assumes a free-running clock; requests change at the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module mfab_mgmt_model (
  input wire logic i_ref_clk,
  output var mfab_pkg::mfab_request_type o_req
);
  initial o_req = '0;
  // calling again at once keeps valid high, so requests run back to back
  task automatic issue(input logic write, input logic [15:0] id);
    @(negedge i_ref_clk);
    o_req = '{valid: 1'b1, write: write, attr_id: id};
  endtask
  task automatic idle();
    @(negedge i_ref_clk);
    o_req = '0;
  endtask
endmodule
`default_nettype wire

// ---- tb_mfab_bank.sv ----
/*
  self-checking bench of the functional attribute bank.
  assumes the management model drives requests; answers one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
`include "mfab_defines.svh"
module tb_mfab_bank;
  logic i_ref_clk;
  logic i_rst;
  logic i_attr_load;
  mfab_pkg::mfab_attr_type i_attr;
  mfab_pkg::mfab_attr_type model;
  mfab_pkg::mfab_attr_type a;
  mfab_pkg::mfab_request_type req;
  mfab_pkg::mfab_answer_type o_ans;
  logic [48:0] q[$];
  logic [191:0] r;
  integer seed;
  integer n_mismatch;
  integer num_checks;

  mfab_bank u_mfab_bank (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_attr_load(i_attr_load),
    .i_attr(i_attr), .i_req(req), .o_ans(o_ans));
  mfab_mgmt_model u_mfab_mgmt_model (.i_ref_clk(i_ref_clk), .o_req(req));

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  function automatic logic [48:0] expect_ans(input mfab_pkg::mfab_attr_type v, input logic w,
    input logic [15:0] id);
    logic t;
    logic b;
    logic [47:0] d;
    logic hit;
    t = v.node_functional_state == `MFAB_STATE_TERMINAL;
    b = v.node_functional_state == `MFAB_STATE_BASE;
    d = '0;
    hit = 1'b1;
    case (id)
      16'h0020: d[15:0] = v.local_node_id > `MFAB_NODE_ID_MAX ?
        `MFAB_NODE_ID_MAX : v.local_node_id;
      16'h0021: d[7:0] = t ? 8'h00 : v.local_switch_id;
      16'h0022: d[7:0] = b ? 8'h00 : v.upstream_switch_id;
      16'h0023: d = v.subnetwork_address;
      16'h0024: d[1:0] = v.node_functional_state;
      16'h0025: d[15:0] = v.contention_period_length;
      16'h0026: d[7:0] = v.hierarchy_level & 8'h3F;
      16'h0027: d[7:0] = v.beacon_slot_count & 8'h07;
      16'h0028: d[7:0] = b ? 8'h00 : v.beacon_receive_slot & 8'h07;
      16'h0029: d[7:0] = t ? 8'h00 : v.beacon_transmit_slot & 8'h07;
      16'h002A: d[7:0] = b ? 8'h00 : v.beacon_receive_interval & 8'h1F;
      16'h002B: d[7:0] = t ? 8'h00 : v.beacon_transmit_interval & 8'h1F;
      16'h002C: d[15:0] = v.capability_bitmap & 16'h0F7F;
      default: hit = 1'b0;
    endcase
    if (w) begin
      hit = 1'b0;
      d = '0;
    end
    return {hit, d};
  endfunction

  task automatic check(input string name, input logic [48:0] exp, input logic [48:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic get(input logic w, input logic [15:0] id);
    u_mfab_mgmt_model.issue(w, id);
    q.push_back(expect_ans(model, w, id));
  endtask

  task automatic read_all();
    for (int i = 16'h1F; i <= 16'h2D; i++) begin
      get(1'b0, 16'(i));
    end
  endtask

  task automatic load(input mfab_pkg::mfab_attr_type v);
    @(negedge i_ref_clk);
    i_attr = v;
    i_attr_load = 1'b1;
    @(negedge i_ref_clk);
    i_attr_load = 1'b0;
    model = v;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // answers are looked at mid-cycle, clear of the launching edge
  always @(negedge i_ref_clk) begin
    if (o_ans.valid === 1'b1) begin
      if (q.size() == 0) begin
        n_mismatch++;
        $display("ERROR answer expected none seen %h", o_ans.data);
      end else begin
        check("answer", q.pop_front(), {o_ans.hit, o_ans.data});
      end
    end
  end

  initial begin
    #100000;
    n_mismatch++;
    $display("ERROR watchdog expected finish seen timeout");
    results();
  end

  initial begin
    seed = 40957;
    n_mismatch = 0;
    num_checks = 0;
    model = '0;
    i_rst = 1'b1;
    i_attr_load = 1'b0;
    i_attr = '0;
    repeat (4) @(negedge i_ref_clk);
    i_rst = 1'b0;
    read_all();
    for (int s = 0; s < 9; s++) begin
      u_mfab_mgmt_model.idle();
      r = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed),
        $random(seed)};
      a = r[161:0];
      a.node_functional_state = s[1:0];
      if (s == 4) a.local_node_id = 16'h3FFF;
      if (s == 5) a.local_node_id = 16'h4000;
      load(a);
      if (s == 8) begin
        // a second reset must clear what was just loaded
        i_rst = 1'b1;
        repeat (4) @(negedge i_ref_clk);
        i_rst = 1'b0;
        model = '0;
      end
      read_all();
      get(1'b1, 16'h0024);
      get(1'b1, 16'h0020);
      get(1'b0, 16'h0024);
      get(1'b0, 16'h0020);
    end
    u_mfab_mgmt_model.idle();
    repeat (3) @(negedge i_ref_clk);
    check("pending", 49'h0, 49'(q.size()));
    results();
  end
endmodule
`default_nettype wire
